//--- msd_pkg.sv
// package of constants and carrier types for the memory space decoder
package msd_pkg;

  // =========================================================
  // register addresses in special function register space
  localparam logic [7:0] ROM_BANK_CONTROL_ADDR = 8'hAB;
  localparam logic [7:0] POWER_MGMT_ADDR       = 8'hC4;
  localparam logic [7:0] PORT1_ADDR            = 8'h90;
  localparam logic [7:0] PORT4_ADDR            = 8'hA5;
  localparam logic [7:0] STROBE_CTRL_ADDR      = 8'hA2;
  localparam logic [7:0] SFR_BASE              = 8'h80;

  // =========================================================
  // field positions
  localparam int BANK_MODE_BIT    = 3;
  localparam int PIN_SEL_LSB      = 0;
  localparam int DATA_RAM_EN_BIT  = 0;
  localparam int STROBE_INV_LSB   = 4;

  // =========================================================
  // values after reset
  localparam logic [3:0] ROM_BANK_CONTROL_RST = 4'h7;
  localparam logic [7:0] POWER_MGMT_RST       = 8'h00;
  localparam logic [7:0] PORT1_RST            = 8'hFF;
  localparam logic [3:0] PORT4_RST            = 4'hF;
  localparam logic [7:0] STROBE_CTRL_RST      = 8'h00;
  localparam logic [7:0] CHIP_SEL_RST         = 8'h00;

  // =========================================================
  // memory sizes and limits
  localparam int               SCRATCH_BYTES  = 256;
  localparam int               DATA_RAM_BYTES = 1024;
  localparam logic [15:0]      DATA_RAM_TOP   = 16'h03FF;
  localparam logic [7:0]       UNUSED_READ    = 8'hFF;

  // =========================================================
  // core access carriers
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } msd_xdata_req_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       direct;
    logic [7:0] addr;
    logic [7:0] wdata;
  } msd_iram_req_t;

  // per pin chip-select setup: mode, mask, base
  typedef struct packed {
    logic [1:0]  mode;
    logic [1:0]  mask;
    logic [15:0] base;
  } msd_cs_cfg_t;

endpackage

//--- msd_scratch_ram.sv
// internal 256 byte scratchpad with direct and indirect access
`timescale 1ns/1ps
module msd_scratch_ram #(
  parameter int DEPTH = msd_pkg::SCRATCH_BYTES
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire msd_pkg::msd_iram_req_t req,
  output logic                        sfrHit,
  output logic [7:0]                  rdata
);

  logic [7:0] mem [DEPTH];

  // upper half on direct access belongs to the register space
  assign sfrHit = req.direct && (req.addr >= msd_pkg::SFR_BASE); // [RULE8]

  always_ff @(posedge ref_clk)
  begin
    if (req.wr && !sfrHit)
    begin
      mem[req.addr] <= req.wdata; // [RULE7]
    end
  end

  // read is combinational; the caller registers the byte
  always_comb
  begin
    rdata = mem[req.addr]; // [RULE7]
  end

endmodule

//--- msd_memory_space_decoder.sv
// memory space decoder: flash banking, data ram mapping, register space, port 4 strobes
`timescale 1ns/1ps

// Contract
// RULE1 - two 64KB program banks; first bank used after reset until software changes
// RULE2 - banking enable drives a chosen port-1 pin as address line A16
// RULE3 - three-bit field picks port-1 pin 0..7 for A16; pin 7 default
// RULE4 - 1KB data ram sits at 0000h-03FFh only while its enable bit set
// RULE5 - with ram enabled, data moves above 03FFh go to the external bus
// RULE6 - ram disabled by default; all data moves go to external bus
// RULE7 - 256 byte scratchpad reachable by direct and indirect addressing
// RULE8 - register space 80h-FFh answers direct addressing only
// RULE9 - registers at addresses ending 0 or 8 are bit addressable
// RULE10 - unimplemented registers and bits read as ones
// RULE11 - write strobe with inversion set gives positive pulse on decoded writes
// RULE12 - general purpose port-4 pins output written port-4 register bits
// RULE13 - banking off leaves pin ordinary and fetches use first bank only
module msd_memory_space_decoder #(
  parameter int RAM_DEPTH = msd_pkg::DATA_RAM_BYTES
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic [15:0]             fetchAddr,
  input  wire msd_pkg::msd_xdata_req_t xReq,
  input  wire msd_pkg::msd_iram_req_t  iReq,
  input  wire logic                    bitOp,
  input  wire logic [2:0]              bitIdx,
  input  wire logic [7:0]              extRdata,
  input  wire msd_pkg::msd_cs_cfg_t    csCfg0,
  input  wire msd_pkg::msd_cs_cfg_t    csCfg1,
  input  wire msd_pkg::msd_cs_cfg_t    csCfg2,
  input  wire msd_pkg::msd_cs_cfg_t    csCfg3,
  output logic [16:0]                  flashAddr,
  output logic [7:0]                   port1Out,
  output logic [3:0]                   port4Out,
  output logic                         extRd,
  output logic                         extWr,
  output logic [15:0]                  extAddr,
  output logic [7:0]                   extWdata,
  output logic [7:0]                   xRdata,
  output logic [7:0]                   iRdata,
  output logic                         iBit
);

  // =========================================================
  // register state
  logic [3:0]  romBankControl;
  logic [7:0]  powerMgmt;
  logic [7:0]  port1Latch;
  logic [3:0]  port4Latch;
  logic [7:0]  strobeCtrl;
  logic        bankModeEnable;
  logic [2:0]  highAddrPinSelect;
  logic        onchipDataRamEnable;
  logic        sfrWrite;
  logic        sfrRead;
  logic [7:0]  sfrRdata;
  logic [7:0]  scratchRdata;
  logic        sfrHit;
  logic [7:0]  readByte;
  logic [7:0]  dataRam [RAM_DEPTH];
  logic        ramHit;
  logic [3:0]  csHit;
  logic [3:0]  next_port4;
  logic [7:0]  next_port1;

  assign bankModeEnable      = romBankControl[msd_pkg::BANK_MODE_BIT];
  assign highAddrPinSelect   = romBankControl[msd_pkg::PIN_SEL_LSB +: 3];
  assign onchipDataRamEnable = powerMgmt[msd_pkg::DATA_RAM_EN_BIT];

  // =========================================================
  // register space access
  assign sfrWrite = iReq.wr && sfrHit; // [RULE8]
  assign sfrRead  = iReq.rd && sfrHit; // [RULE8]

  // bit addressable registers have address low nibble 0 or 8
  function automatic logic bitAddressable(input logic [7:0] a);
    return a[2:0] == 3'h0;
  endfunction

  function automatic logic [7:0] applyWrite(input logic [7:0] old, input logic [7:0] a);
    logic [7:0] r;
    r = iReq.wdata;
    if (bitOp && bitAddressable(a)) // [RULE9]
    begin
      r = old;
      r[bitIdx] = iReq.wdata[0];
    end
    return r;
  endfunction

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      romBankControl <= msd_pkg::ROM_BANK_CONTROL_RST; // [RULE1] [RULE3]
    end
    else if (sfrWrite && iReq.addr == msd_pkg::ROM_BANK_CONTROL_ADDR)
    begin
      romBankControl <= iReq.wdata[3:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      powerMgmt <= msd_pkg::POWER_MGMT_RST; // [RULE6]
    end
    else if (sfrWrite && iReq.addr == msd_pkg::POWER_MGMT_ADDR)
    begin
      powerMgmt <= {7'h00, iReq.wdata[msd_pkg::DATA_RAM_EN_BIT]};
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      port1Latch <= msd_pkg::PORT1_RST;
    end
    else if (sfrWrite && iReq.addr == msd_pkg::PORT1_ADDR)
    begin
      port1Latch <= applyWrite(port1Latch, iReq.addr); // [RULE9]
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      port4Latch <= msd_pkg::PORT4_RST;
    end
    else if (sfrWrite && iReq.addr == msd_pkg::PORT4_ADDR)
    begin
      port4Latch <= iReq.wdata[3:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      strobeCtrl <= msd_pkg::STROBE_CTRL_RST;
    end
    else if (sfrWrite && iReq.addr == msd_pkg::STROBE_CTRL_ADDR)
    begin
      strobeCtrl <= iReq.wdata;
    end
  end

  // read mux; unused bits and absent registers return ones
  always_comb
  begin
    unique case (iReq.addr)
      msd_pkg::ROM_BANK_CONTROL_ADDR: sfrRdata = {4'hF, romBankControl}; // [RULE10]
      msd_pkg::POWER_MGMT_ADDR:       sfrRdata = {7'h7F, powerMgmt[0]};  // [RULE10]
      msd_pkg::PORT1_ADDR:            sfrRdata = port1Latch;
      msd_pkg::PORT4_ADDR:            sfrRdata = {4'hF, port4Latch};     // [RULE10]
      msd_pkg::STROBE_CTRL_ADDR:      sfrRdata = strobeCtrl;
      default:                        sfrRdata = msd_pkg::UNUSED_READ;   // [RULE10]
    endcase
  end

  msd_scratch_ram #(
    .DEPTH (msd_pkg::SCRATCH_BYTES)
  ) u_scratch (
    .ref_clk (ref_clk),
    .rst     (rst),
    .req     (iReq),
    .sfrHit  (sfrHit),
    .rdata   (scratchRdata)
  );

  // one cycle read latency for both spaces
  assign readByte = sfrRead ? sfrRdata : scratchRdata;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      iRdata <= 8'h00;
      iBit   <= 1'b0;
    end
    else if (iReq.rd)
    begin
      iRdata <= readByte; // [RULE7] [RULE8]
      iBit   <= bitOp && bitAddressable(iReq.addr) && readByte[bitIdx]; // [RULE9]
    end
  end

  // =========================================================
  // program fetch banking
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      flashAddr <= 17'h00000;
    end
    else
    begin
      flashAddr <= {bankModeEnable & port1Out[highAddrPinSelect], fetchAddr}; // [RULE2] [RULE13]
    end
  end

  always_comb
  begin
    next_port1 = port1Latch; // [RULE13]
    if (bankModeEnable)
    begin
      next_port1[highAddrPinSelect] = port1Latch[highAddrPinSelect]; // [RULE2] [RULE3]
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      port1Out <= msd_pkg::PORT1_RST;
    end
    else
    begin
      port1Out <= next_port1;
    end
  end

  // =========================================================
  // external data move routing
  assign ramHit = onchipDataRamEnable && (xReq.addr <= msd_pkg::DATA_RAM_TOP); // [RULE4] [RULE5]

  always_ff @(posedge ref_clk)
  begin
    if (xReq.wr && ramHit)
    begin
      dataRam[xReq.addr[9:0]] <= xReq.wdata; // [RULE4]
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      extRd    <= 1'b0;
      extWr    <= 1'b0;
      extAddr  <= 16'h0000;
      extWdata <= 8'h00;
      xRdata   <= 8'h00;
    end
    else
    begin
      extRd <= xReq.rd && !ramHit; // [RULE5] [RULE6]
      extWr <= xReq.wr && !ramHit; // [RULE5] [RULE6]
      if ((xReq.rd || xReq.wr) && !ramHit)
      begin
        extAddr  <= xReq.addr;
        extWdata <= xReq.wdata;
      end
      if (xReq.rd)
      begin
        xRdata <= ramHit ? dataRam[xReq.addr[9:0]] : extRdata; // [RULE4]
      end
    end
  end

  // =========================================================
  // port 4 chip selects
  function automatic logic csMatch(input msd_pkg::msd_cs_cfg_t c);
    logic [15:0] m;
    m = {14'h3FFF, ~c.mask};
    return ((xReq.addr & m) == (c.base & m)) &&
           ((c.mode[1] && xReq.wr) || (c.mode[0] && xReq.rd));
  endfunction

  assign csHit = {csMatch(csCfg3), csMatch(csCfg2), csMatch(csCfg1), csMatch(csCfg0)};

  always_comb
  begin
    msd_pkg::msd_cs_cfg_t cfgs [4];
    cfgs[0] = csCfg0;
    cfgs[1] = csCfg1;
    cfgs[2] = csCfg2;
    cfgs[3] = csCfg3;
    for (int i = 0; i < 4; i++)
    begin
      if (cfgs[i].mode == 2'b00)
      begin
        next_port4[i] = port4Latch[i]; // [RULE12]
      end
      else
      begin
        // active low strobe, inverted to positive when selected
        next_port4[i] = ~csHit[i] ^ strobeCtrl[msd_pkg::STROBE_INV_LSB + i]; // [RULE11]
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      port4Out <= msd_pkg::PORT4_RST;
    end
    else
    begin
      port4Out <= next_port4;
    end
  end

endmodule

//--- msd_properties.sv
// checker of port behaviour for the memory space decoder
`timescale 1ns/1ps
module msd_properties (
  input wire logic                    ref_clk,
  input wire logic                    rst,
  input wire logic [15:0]             fetchAddr,
  input wire msd_pkg::msd_xdata_req_t xReq,
  input wire msd_pkg::msd_iram_req_t  iReq,
  input wire logic                    bitOp,
  input wire msd_pkg::msd_cs_cfg_t    csCfg0,
  input wire logic [16:0]             flashAddr,
  input wire logic [7:0]              port1Out,
  input wire logic [3:0]              port4Out,
  input wire logic                    extRd,
  input wire logic                    extWr,
  input wire logic [15:0]             extAddr,
  input wire logic [7:0]              extWdata,
  input wire logic [7:0]              iRdata
);
  logic       ramEn;
  logic [3:0] romCtl;
  logic       inv0;
  logic       dirWr;
  logic       xExt;
  logic       csHit;
  assign dirWr = iReq.wr && iReq.direct;
  assign xExt  = !ramEn || (xReq.addr > msd_pkg::DATA_RAM_TOP);
  assign csHit = ((xReq.addr ^ csCfg0.base) & ~{14'h0000, csCfg0.mask}) == 16'h0000;
  // =========================================================
  // shadow of control bits
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ramEn  <= 1'b0;
      romCtl <= msd_pkg::ROM_BANK_CONTROL_RST;
      inv0   <= 1'b0;
    end
    else if (dirWr)
    begin
      if (iReq.addr == msd_pkg::POWER_MGMT_ADDR)
        ramEn <= iReq.wdata[0];
      if (iReq.addr == msd_pkg::ROM_BANK_CONTROL_ADDR)
        romCtl <= iReq.wdata[3:0];
      if (iReq.addr == msd_pkg::STROBE_CTRL_ADDR)
        inv0 <= iReq.wdata[4];
    end
  end
  // =========================================================
  // assertions
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  AST_FETCH: assert property ($past(!rst) |-> flashAddr[15:0] == $past(fetchAddr))
    else $error("flash address does not follow fetch address");
  AST_BANK_OFF: assert property ($past(!rst) && !$past(romCtl[3]) |-> !flashAddr[16])
    else $error("bank bit set while banking is off");
  AST_BANK_PIN: assert property ($past(romCtl[3]) && $stable(romCtl) && $stable(port1Out)
    |-> flashAddr[16] == port1Out[romCtl[2:0]])
    else $error("bank bit differs from selected port pin");
  AST_EXT_WR: assert property (xReq.wr && xExt
    |=> extWr && extAddr == $past(xReq.addr) && extWdata == $past(xReq.wdata))
    else $error("data write not placed on external bus");
  AST_EXT_RD: assert property (xReq.rd && xExt |=> extRd && extAddr == $past(xReq.addr))
    else $error("data read not placed on external bus");
  AST_RAM_ACC: assert property ((xReq.wr || xReq.rd) && !xExt |=> !extWr && !extRd)
    else $error("on-chip data access leaked to external bus");
  AST_IND_WR: assert property (iReq.wr && !iReq.direct |-> ##2 $stable(port1Out))
    else $error("indirect write reached port register");
  AST_P1_WR: assert property (dirWr && !bitOp && iReq.addr == msd_pkg::PORT1_ADDR
    |-> ##2 port1Out == $past(iReq.wdata, 2))
    else $error("direct port write not applied");
  AST_ABSENT: assert property (iReq.rd && iReq.direct && iReq.addr == 8'h84
    |=> iRdata == msd_pkg::UNUSED_READ)
    else $error("absent register did not read ones");
  AST_STROBE: assert property (xReq.wr && csHit && csCfg0.mode[1] && inv0
    |=> port4Out[0] ##1 !port4Out[0])
    else $error("positive write strobe missing");
  COV_STROBE: cover property (xReq.wr && csHit && inv0);
  COV_BANK: cover property (romCtl[3] && flashAddr[16]);
  COV_RAM: cover property (xReq.rd && !xExt);
endmodule

bind msd_memory_space_decoder msd_properties i_props (.ref_clk, .rst, .fetchAddr, .xReq, .iReq,
  .bitOp, .csCfg0, .flashAddr, .port1Out, .port4Out, .extRd, .extWr, .extAddr, .extWdata, .iRdata);

//--- msd_ext_mem.sv
// external data memory model on the multiplexed bus
`timescale 1ns/1ps
module msd_ext_mem (
  input  wire logic        ref_clk,
  input  wire logic        reqRd,
  input  wire logic [15:0] reqAddr,
  input  wire logic        extWr,
  input  wire logic [15:0] extAddr,
  input  wire logic [7:0]  extWdata,
  output logic [7:0]       extRdata
);
  logic [7:0] mem [logic [15:0]];
  // =========================================================
  // store writes
  always @(posedge ref_clk)
  begin
    if (extWr)
      mem[extAddr] = extWdata;
  end
  // released bus floats to its pull-up level
  always @*
  begin
    if (!reqRd)
      extRdata = 8'hFF;
    else if (mem.exists(reqAddr))
      extRdata = mem[reqAddr];
    else
      extRdata = ~reqAddr[7:0];
  end
endmodule

//--- testbench.sv
// self-checking bench for the memory space decoder
`timescale 1ns/1ps
module testbench;
  logic                    ref_clk;
  logic                    rst;
  logic [15:0]             fetchAddr;
  msd_pkg::msd_xdata_req_t xReq;
  msd_pkg::msd_iram_req_t  iReq;
  logic                    bitOp;
  logic [2:0]              bitIdx;
  logic [7:0]              extRdata;
  msd_pkg::msd_cs_cfg_t    csCfg0;
  msd_pkg::msd_cs_cfg_t    csCfg1;
  logic [16:0]             flashAddr;
  logic [7:0]              port1Out;
  logic [3:0]              port4Out;
  logic                    extRd;
  logic                    extWr;
  logic [15:0]             extAddr;
  logic [7:0]              extWdata;
  logic [7:0]              xRdata;
  logic [7:0]              iRdata;
  logic                    iBit;
  wire logic [24:0]        extBus = {extWr, extAddr, extWdata};
  int                      n_errors = 0;
  int                      check_count = 0;

  msd_memory_space_decoder i_dut (.ref_clk, .rst, .fetchAddr, .xReq, .iReq, .bitOp, .bitIdx,
    .extRdata, .csCfg0, .csCfg1, .csCfg2(csCfg1), .csCfg3(csCfg1), .flashAddr, .port1Out,
    .port4Out, .extRd, .extWr, .extAddr, .extWdata, .xRdata, .iRdata, .iBit);
  msd_ext_mem i_mem (.ref_clk, .reqRd(xReq.rd), .reqAddr(xReq.addr), .extWr, .extAddr,
    .extWdata, .extRdata);

  // =========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [24:0] exp, input logic [24:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  task automatic iop(input logic w, input logic d, input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    #1;
    iReq = '{rd: !w, wr: w, direct: d, addr: a, wdata: v};
    @(posedge ref_clk);
    #1;
    iReq = '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    iop(1'b1, 1'b1, a, v);
  endtask
  task automatic xop(input logic w, input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    #1;
    xReq = '{rd: !w, wr: w, addr: a, wdata: v};
    @(posedge ref_clk);
    #1;
    xReq = '0;
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic finish_test();
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // =========================================================
  // scenarios
  task automatic t_reset();
    chk("port4", 25'h000000F, port4Out);
    chk("a16", 25'h0, flashAddr[16]);
    iop(1'b0, 1'b1, 8'hAB, 8'h00);
    chk("romctl", 25'h00000F7, iRdata);
    iop(1'b0, 1'b1, 8'hC4, 8'h00);
    chk("ramen", 25'h0, iRdata[0]);
  endtask
  task automatic t_bank();
    fetchAddr = 16'hABCD;
    wr(8'h90, 8'hFF);
    settle();
    chk("flash", 25'h000ABCD, flashAddr);
    for (int s = 0; s < 8; s++)
    begin
      wr(8'hAB, 8'h08 | 8'(s));
      wr(8'h90, 8'h01 << s);
      settle();
      chk("a16hi", 25'h001ABCD, flashAddr);
      wr(8'h90, ~(8'h01 << s));
      settle();
      chk("a16lo", 25'h000ABCD, flashAddr);
    end
    wr(8'hAB, 8'h07);
  endtask
  task automatic t_xdata();
    xop(1'b1, 16'h0010, 8'h5A);
    chk("ext", 25'h100105A, extBus);
    wr(8'hC4, 8'h01);
    xop(1'b1, 16'h03FF, 8'hA5);
    chk("ramwr", 25'h0, extWr);
    xop(1'b0, 16'h03FF, 8'h00);
    chk("ramrd", 25'h00000A5, {extRd, xRdata});
    xop(1'b1, 16'h0400, 8'h3C);
    chk("ext", 25'h104003C, extBus);
    xop(1'b0, 16'h0400, 8'h00);
    chk("extrd", 25'h000013C, {extRd, xRdata});
    wr(8'hC4, 8'h00);
    xop(1'b0, 16'h03FF, 8'h00);
    chk("extrd", 25'h0000100, {extRd, xRdata});
  endtask
  task automatic t_iram();
    wr(8'h30, 8'h77);
    iop(1'b0, 1'b0, 8'h30, 8'h00);
    chk("ind", 25'h0000077, iRdata);
    wr(8'h90, 8'hC3);
    iop(1'b1, 1'b0, 8'h90, 8'h12);
    chk("p1", 25'h00000C3, port1Out);
    iop(1'b0, 1'b0, 8'h90, 8'h00);
    chk("ind", 25'h0000012, iRdata);
    iop(1'b0, 1'b1, 8'h90, 8'h00);
    chk("dir", 25'h00000C3, iRdata);
    bitOp = 1'b1;
    bitIdx = 3'h6;
    iop(1'b0, 1'b1, 8'h90, 8'h00);
    chk("bit6", 25'h1, iBit);
    bitIdx = 3'h2;
    iop(1'b0, 1'b1, 8'h90, 8'h00);
    chk("bit2", 25'h0, iBit);
    bitIdx = 3'h3;
    wr(8'h90, 8'h01);
    settle();
    chk("bitwr", 25'h00000CB, port1Out);
    bitOp = 1'b0;
    iop(1'b0, 1'b1, 8'h84, 8'h00);
    chk("absent", 25'h00000FF, iRdata);
  endtask
  task automatic t_p4();
    csCfg0 = '{mode: 2'b10, mask: 2'b11, base: 16'h1234};
    wr(8'hA2, 8'h10);
    wr(8'hA5, 8'h05);
    settle();
    chk("p4gp", 25'h2, port4Out[3:1]);
    xop(1'b1, 16'h1236, 8'h55);
    chk("strobe", 25'h5, port4Out);
    @(posedge ref_clk);
    #1;
    chk("strobe", 25'h4, port4Out);
    xop(1'b1, 16'h1238, 8'h55);
    chk("nostrobe", 25'h0, port4Out[0]);
    csCfg1 = '{mode: 2'b01, mask: 2'b00, base: 16'h2000};
    xop(1'b0, 16'h2000, 8'h00);
    chk("rdstrobe", 25'h0, port4Out[3:1]);
    @(posedge ref_clk);
    #1;
    chk("rdidle", 25'h7, port4Out[3:1]);
  endtask

  // =========================================================
  // clock, sequence, watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial
  begin
    rst = 1'b1;
    fetchAddr = 16'h0000;
    xReq = '0;
    iReq = '0;
    bitOp = 1'b0;
    bitIdx = 3'h0;
    csCfg0 = '0;
    csCfg1 = '0;
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_bank();
    t_xdata();
    t_iram();
    t_p4();
    finish_test();
  end
  initial
  begin
    #100000;
    n_errors++;
    finish_test();
  end
endmodule
